// *** hdl/smc_ctrl.sv ***
// standby mode controller: mode register, entry, bus state and release
// Notes on behaviour
// RL1 - mode field 00 halt, 10 idle, 11 stop, 01 prohibited; acts at halt instruction; code serves only 00 and 10, 11 falls through like 01
// RL2 - halt instruction with 00 runs halt acknowledge then enters halt
// RL3 - halt stops cpu clock only, peripherals keep running
// RL4 - entry waits until a running dma block transfer finishes
// RL5 - single transfer returns bus at cycle end, then acknowledge and entry
// RL6 - halt drives pc on address, floats data, strobes high except refresh
// RL7 - while hold granted in halt or idle, address, selects and strobes float
// RL8 - halt exits on nmi, unmasked maskable interrupt, or reset
// RL9 - maskable interrupt releases halt only when interrupt disable flag is 0
// RL10 - software enables a releasing interrupt before halting inside a handler
// RL11 - nmi source holds level until the handler branch
// RL12 - halt instruction with 10 runs acknowledge, self-refresh, enters idle
// RL13 - idle gates system clock off, oscillator and pll kept running
// RL14 - idle exit resumes at once, no settling wait
// RL15 - hold accepted in idle, floats bus, refresh restarts after release
// RL16 - hold ignored in acknowledge and first six refresh cycles after idle entry; code ignores it through all eight burst cycles
// RL17 - idle exits only on nmi or reset
// RL18 - external system avoids nmi while refresh output inactive or floating
// RL19 - software clears nmi pending flag before idle from nmi handler
// RL20 - reset during halt or idle releases as ordinary reset
// RL21 - settle-wait field selects two to the 19 down to 16 clock periods
// RL22 - writes need key 0111, key reads back 0000
`timescale 1ns/1ps
module smc_ctrl
    import smc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic halt_exec,
    input wire logic dma_block_busy,
    input wire logic dma_single_busy,
    input wire logic nmi_n,
    input wire logic irq_unmasked,
    input wire logic interrupt_disable_flag,
    input wire logic hold_request_n,
    output logic hold_acknowledge_n,
    output logic halt_ack_cycle,
    output logic cpu_clk_en,
    output logic sys_clk_en,
    output logic nmi_wake,
    output logic [4:0] settle_count_exp,
    output smc_bus_t bus_state
);
    // offsets are eight bits wide: wider decode would read past them
    if (ADDR_W < 3 || ADDR_W > 8)
        $error("smc_ctrl: address width must be 3 to 8");

    // halt and idle are the only modes served here
    function automatic logic smc_mode_served(input logic [1:0] m);
        smc_mode_served = m == SMC_MODE_HALT || m == SMC_MODE_IDLE;
    endfunction

    typedef enum logic [5:0] {
        SMC_RUN = 6'h01,
        SMC_WAIT = 6'h02,
        SMC_HACK = 6'h04,
        SMC_HALT = 6'h08,
        SMC_IREF = 6'h10,
        SMC_IDLE = 6'h20
    } smc_state_t;

    smc_state_t state_q, state_d;
    logic [3:0] ctrl_q;
    logic [7:0] rdata_q;
    logic [3:0] cnt_q, cnt_d;
    logic hold_q;
    logic is_halt_tgt_q;
    logic [2:0] nmi_sync_q;
    logic [2:0] hold_sync_q;
    logic nmi_act_q, hold_req_q;
    logic wake_q;

    // nmi and hold come from pins: three stages, change counts when last two agree
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            nmi_sync_q <= 3'h7;
            hold_sync_q <= 3'h7;
            nmi_act_q <= 1'b0;
            hold_req_q <= 1'b0;
        end
        else
        begin
            nmi_sync_q <= {nmi_sync_q[1:0], nmi_n};
            hold_sync_q <= {hold_sync_q[1:0], hold_request_n};
            if (nmi_sync_q[2] == nmi_sync_q[1])
                nmi_act_q <= ~nmi_sync_q[2];
            if (hold_sync_q[2] == hold_sync_q[1])
                hold_req_q <= ~hold_sync_q[2];
        end
    end

    wire ctrl_sel = reg_addr == SMC_CTRL_OFS[ADDR_W-1:0];
    wire stat_sel = reg_addr == SMC_STAT_OFS[ADDR_W-1:0];
    wire key_ok = reg_wdata[7:SMC_KEY_POS] == SMC_KEY_VAL; // RL22
    wire ctrl_we = reg_wr && ctrl_sel && key_ok && state_q == SMC_RUN; // RL22
    wire [1:0] mode_sel = ctrl_q[1:0];
    // prohibited code ignored and stop not served here: instruction falls through
    wire mode_ok = smc_mode_served(mode_sel); // RL1
    wire dma_block = dma_block_busy || dma_single_busy; // RL4 RL5
    wire halt_rel = nmi_act_q || (irq_unmasked && !interrupt_disable_flag); // RL8 RL9
    wire idle_rel = nmi_act_q; // RL17
    wire in_standby = state_q == SMC_HALT || state_q == SMC_IREF || state_q == SMC_IDLE;
    wire hold_ok = state_q == SMC_HALT || (state_q == SMC_IDLE); // RL16
    wire [7:0] stat_word = {2'h0, state_q};
    wire [7:0] rd_word = ctrl_sel ? {4'h0, ctrl_q} : (stat_sel ? stat_word : 8'h00);

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SMC_RUN:
            begin
                if (halt_exec && mode_ok) // RL1
                    state_d = dma_block ? SMC_WAIT : SMC_HACK; // RL4
                cnt_d = 4'h0;
            end
            SMC_WAIT:
            begin
                if (!dma_block) // RL4 RL5
                    state_d = SMC_HACK;
                cnt_d = 4'h0;
            end
            SMC_HACK:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(SMC_HACK_CYC - 1))
                begin
                    cnt_d = 4'h0;
                    state_d = is_halt_tgt_q ? SMC_HALT : SMC_IREF; // RL2 RL12
                end
            end
            SMC_HALT:
            begin
                if (halt_rel && !hold_q) // RL8
                    state_d = SMC_RUN;
            end
            SMC_IREF:
            begin
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(SMC_REF_CYC - 1))
                begin
                    cnt_d = 4'h0;
                    state_d = SMC_IDLE;
                end
            end
            SMC_IDLE:
            begin
                if (hold_q && !hold_req_q)
                    state_d = SMC_IREF; // RL15
                else if (idle_rel && !hold_q)
                    state_d = SMC_RUN; // RL14 RL17
            end
            default:
                state_d = SMC_RUN;
        endcase
    end

    // reset is asynchronous: any standby state returns to run as at power-up
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= SMC_RUN; // RL20
            cnt_q <= 4'h0;
            ctrl_q <= SMC_CTRL_RST;
            rdata_q <= 8'h00;
            is_halt_tgt_q <= 1'b1;
            wake_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (ctrl_we)
                ctrl_q <= reg_wdata[3:0]; // RL22
            rdata_q <= reg_rd ? rd_word : 8'h00; // RL22
            if (state_q == SMC_RUN && halt_exec)
                is_halt_tgt_q <= mode_sel == SMC_MODE_HALT;
            wake_q <= in_standby && state_d == SMC_RUN && nmi_act_q;
        end
    end

    // hold grant; blanked during acknowledge and the opening refresh burst
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            hold_q <= 1'b0;
        else if (!hold_req_q)
            hold_q <= 1'b0;
        else if (hold_ok)
            hold_q <= 1'b1; // RL15 RL16
    end

    wire refreshing = state_q == SMC_IREF || state_q == SMC_IDLE;
    wire ref_pulse = state_q == SMC_IREF && cnt_q < 4'(SMC_HOLD_BLANK_CYC);
    smc_bus_t bus_w;
    always_comb
    begin
        bus_w.addr_pc = in_standby || state_q == SMC_HACK; // RL6
        bus_w.data_oe = 1'b0; // RL6
        bus_w.ctl_oe = !hold_q; // RL7
        bus_w.strobes_high = 1'b1; // RL6
        bus_w.ras_n = !(refreshing && !hold_q); // RL12 RL15
        bus_w.cas_n = !(refreshing && !hold_q && (ref_pulse || state_q == SMC_IDLE));
        bus_w.refresh_request_out_n = !(refreshing && !hold_q);
    end

    assign bus_state = in_standby || state_q == SMC_HACK ? bus_w : 7'h1F;
    assign reg_rdata = rdata_q;
    assign hold_acknowledge_n = !hold_q;
    assign halt_ack_cycle = state_q == SMC_HACK;
    assign cpu_clk_en = !in_standby && state_q != SMC_HACK; // RL3
    assign sys_clk_en = !refreshing; // RL13
    assign nmi_wake = wake_q;
    assign settle_count_exp = SMC_SETTLE_EXP_BASE - {3'h0, ctrl_q[3:SMC_WT_POS]}; // RL21

    AST_KEY_BLOCK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_wr && ctrl_sel && !key_ok |=> ctrl_q == $past(ctrl_q))
        else $error("bad key wrote control"); // RL22
    AST_KEY_READ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_rd |=> reg_rdata[7:4] == 4'h0)
        else $error("key bits read nonzero"); // RL22
    AST_DMA_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_WAIT && dma_block |=> state_q == SMC_WAIT)
        else $error("entry during dma"); // RL4
    AST_HACK_LEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(halt_ack_cycle) |-> halt_ack_cycle [*2] ##1 !halt_ack_cycle)
        else $error("acknowledge length wrong"); // RL2
    AST_HOLD_BLANK: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_HACK && !hold_q |=> !hold_q)
        else $error("hold granted in acknowledge"); // RL16
    AST_DI_NO_REL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_HALT && !nmi_act_q && interrupt_disable_flag |=> state_q == SMC_HALT)
        else $error("masked halt release"); // RL9
    AST_IDLE_IRQ: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_IDLE && !nmi_act_q |=> state_q != SMC_RUN)
        else $error("idle left without nmi"); // RL17
    AST_HOLD_FLOAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hold_q && in_standby |-> !bus_state.ctl_oe && bus_state.ras_n)
        else $error("bus driven under hold"); // RL7
    AST_CLK_GATE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_HALT |-> !cpu_clk_en && sys_clk_en)
        else $error("halt clock gating wrong"); // RL3
    AST_HALT_EXIT: assert property (@(posedge ref_clk) disable iff (sys_rst)
        state_q == SMC_HALT && nmi_act_q && !hold_q |=> cpu_clk_en)
        else $error("nmi did not release halt"); // RL8
    COV_HALT: cover property (@(posedge ref_clk) state_q == SMC_HALT ##1 state_q == SMC_RUN);
    COV_IDLE: cover property (@(posedge ref_clk) state_q == SMC_IDLE ##1 state_q == SMC_RUN);
    COV_HOLD: cover property (@(posedge ref_clk) state_q == SMC_IDLE && hold_q);
    COV_DMA: cover property (@(posedge ref_clk) state_q == SMC_WAIT ##1 state_q == SMC_HACK);
    COV_HOLD_HALT: cover property (@(posedge ref_clk) state_q == SMC_HALT && hold_q);

    AST_HOLD_IREF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL16
        state_q == SMC_IREF && !hold_q |=> !hold_q)
        else $error("hold granted in refresh burst");

    AST_IDLE_REF: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
        state_q == SMC_IDLE && !hold_q |-> !bus_state.refresh_request_out_n && !bus_state.ras_n)
        else $error("no self refresh in idle");

    AST_IDLE_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
        state_q == SMC_IDLE |-> !sys_clk_en && !cpu_clk_en)
        else $error("idle clock gating wrong");

    AST_IDLE_FAST: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL14
        state_q == SMC_IDLE && nmi_act_q && !hold_q |=> cpu_clk_en && sys_clk_en)
        else $error("idle exit delayed");

    AST_HOLD_RESTART: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL15
        state_q == SMC_IDLE && hold_q && !hold_req_q |=> state_q == SMC_IREF)
        else $error("refresh not restarted after hold");

    AST_HALT_BUS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL6
        state_q == SMC_HALT |-> bus_state.addr_pc && !bus_state.data_oe && bus_state.strobes_high && bus_state.ras_n)
        else $error("halt bus state wrong");

    AST_IRQ_EXIT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8
        state_q == SMC_HALT && irq_unmasked && !interrupt_disable_flag && !hold_q |=> cpu_clk_en)
        else $error("unmasked interrupt did not release halt");

    AST_MODE_BAD: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL1
        state_q == SMC_RUN && halt_exec && !mode_ok |=> state_q == SMC_RUN)
        else $error("unserved mode entered standby");

    AST_SINGLE_WAIT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL5
        state_q == SMC_WAIT && dma_single_busy |=> !halt_ack_cycle)
        else $error("acknowledge inside single transfer");

    AST_WT_MAP: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL21
        ctrl_q[3:2] == 2'h3 |-> settle_count_exp == 5'h10)
        else $error("settle exponent wrong");

    AST_RST_RUN: assert property (@(posedge ref_clk) // RL20
        $past(sys_rst) && !sys_rst |-> state_q == SMC_RUN && cpu_clk_en && hold_acknowledge_n)
        else $error("reset did not release standby");

    AST_HACK_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
        halt_ack_cycle |-> !cpu_clk_en && bus_state.addr_pc)
        else $error("acknowledge state wrong");

    AST_KEY_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL22
        reg_wr && ctrl_sel && key_ok && state_q == SMC_RUN |=> {4'h0, ctrl_q} == ($past(reg_wdata) & 8'h0F))
        else $error("keyed write lost");

    AST_HALT_HOLD_GRANT: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL7
        state_q == SMC_HALT && hold_req_q |=> hold_q)
        else $error("hold refused in halt");

    AST_IDLE_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL15
        state_q == SMC_IDLE && hold_req_q |=> hold_q)
        else $error("hold refused in idle");

    AST_HALT_SYS: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL6
        state_q == SMC_HALT && !hold_q |-> bus_state.ctl_oe)
        else $error("selects not driven in halt");

    AST_IREF_CLK: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
        state_q == SMC_IREF |-> !sys_clk_en && !cpu_clk_en)
        else $error("clock runs in refresh burst");

    AST_NMI_WAKE: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8
        nmi_wake |-> cpu_clk_en)
        else $error("wake without cpu clock");

    AST_WAIT_RUN: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL4
        state_q == SMC_WAIT |-> cpu_clk_en && !halt_ack_cycle)
        else $error("standby entered during dma");
endmodule // smc_ctrl

// *** hdl/smc_pkg.sv ***
// package for the standby mode controller
package smc_pkg;
    localparam logic [7:0] SMC_CTRL_OFS = 8'h00;
    localparam logic [7:0] SMC_STAT_OFS = 8'h04;
    localparam logic [3:0] SMC_KEY_VAL = 4'h7;
    localparam int SMC_KEY_POS = 4;
    localparam int SMC_WT_POS = 2;
    localparam int SMC_MODE_POS = 0;
    localparam logic [3:0] SMC_CTRL_RST = 4'h0;
    localparam logic [1:0] SMC_MODE_HALT = 2'h0;
    localparam logic [1:0] SMC_MODE_BAD = 2'h1;
    localparam logic [1:0] SMC_MODE_IDLE = 2'h2;
    localparam logic [1:0] SMC_MODE_STOP = 2'h3;
    localparam int SMC_HACK_CYC = 2;
    localparam int SMC_HOLD_BLANK_CYC = 6;
    localparam int SMC_REF_CYC = 8;
    localparam int SMC_CLK_MHZ = 100;
    localparam logic [4:0] SMC_SETTLE_EXP_BASE = 5'h13;
    typedef struct packed {
        logic addr_pc;
        logic data_oe;
        logic ctl_oe;
        logic strobes_high;
        logic ras_n;
        logic cas_n;
        logic refresh_request_out_n;
    } smc_bus_t;
endpackage

// *** testbench/smc_far_side.sv ***
// far side model: nmi source and external bus master
`timescale 1ns/1ps
module smc_far_side
    import smc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nmi_wake,
    input wire smc_bus_t bus_state,
    output logic nmi_n,
    output logic hold_request_n
);
    initial
    begin
        nmi_n = 1'b1;
        hold_request_n = 1'b1;
    end
    task automatic hold(input logic on);
        @(posedge ref_clk);
        hold_request_n <= !on;
    endtask
    // nmi raised once refresh output active (wait capped at 40 cycles), else the self-refresh restart stalls
    task automatic nmi_pulse();
        int n;
        n = 0;
        while (bus_state.refresh_request_out_n !== 1'b0 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        nmi_n <= 1'b0;
        n = 0;
        while (nmi_wake !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        @(posedge ref_clk);
        nmi_n <= 1'b1;
    endtask
endmodule // smc_far_side

// *** testbench/test_standby_mode_controller.sv ***
// self-checking bench for the standby mode controller
`timescale 1ns/1ps
module test_standby_mode_controller
    import smc_pkg::*;
;
    localparam logic [7:0] ROWS [7][3] = '{'{8'h70, 8'h00, 8'h13}, '{8'h74, 8'h04, 8'h12}, '{8'h78, 8'h08, 8'h11},
        '{8'h7F, 8'h0F, 8'h10}, '{8'h3C, 8'h0F, 8'h10}, '{8'hF0, 8'h0F, 8'h10}, '{8'h72, 8'h02, 8'h13}};
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, halt_exec = 1'b0;
    logic dma_block_busy = 1'b0, dma_single_busy = 1'b0, irq_unmasked = 1'b0, interrupt_disable_flag = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic nmi_n, hold_request_n, hold_acknowledge_n, halt_ack_cycle, cpu_clk_en, sys_clk_en, nmi_wake, seen;
    logic [4:0] settle_count_exp;
    smc_bus_t bus_state;
    int n_mismatch = 0, comparisons = 0, cycles = 0;
    always #5 ref_clk = ~ref_clk;
    smc_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_exec(halt_exec),
        .dma_block_busy(dma_block_busy), .dma_single_busy(dma_single_busy), .nmi_n(nmi_n),
        .irq_unmasked(irq_unmasked), .interrupt_disable_flag(interrupt_disable_flag),
        .hold_request_n(hold_request_n), .hold_acknowledge_n(hold_acknowledge_n), .halt_ack_cycle(halt_ack_cycle),
        .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .nmi_wake(nmi_wake),
        .settle_count_exp(settle_count_exp), .bus_state(bus_state));
    smc_far_side far (.ref_clk(ref_clk), .nmi_wake(nmi_wake), .bus_state(bus_state), .nmi_n(nmi_n),
        .hold_request_n(hold_request_n));
    task automatic close_out();
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask
    task automatic halt();
        @(posedge ref_clk);
        halt_exec <= 1'b1;
        @(posedge ref_clk);
        halt_exec <= 1'b0;
    endtask
    task automatic wait_cpu(input logic v, input int lim);
        int n;
        n = 0;
        while (cpu_clk_en !== v && n < lim)
        begin
            @(negedge ref_clk);
            n++;
        end
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch++;
            close_out();
        end
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(SMC_CTRL_OFS, d);
        chk(d, 8'h00);
        chk({6'h0, cpu_clk_en, sys_clk_en}, 8'h03);
        for (int i = 0; i < 7; i++)
        begin
            wr(SMC_CTRL_OFS, ROWS[i][0]);
            rd(SMC_CTRL_OFS, d);
            chk(d, ROWS[i][1]);
            chk({3'h0, settle_count_exp}, ROWS[i][2]);
        end
        rd(8'h08, d);
        chk(d, 8'h00);
        wr(SMC_CTRL_OFS, 8'h71);
        halt();
        repeat (8) @(negedge ref_clk);
        chk({7'h0, cpu_clk_en}, 8'h01);
        wr(SMC_CTRL_OFS, 8'h70);
        dma_block_busy <= 1'b1;
        halt();
        repeat (10) @(negedge ref_clk);
        chk({7'h0, cpu_clk_en}, 8'h01);
        @(posedge ref_clk);
        dma_block_busy <= 1'b0;
        dma_single_busy <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk({7'h0, cpu_clk_en}, 8'h01);
        @(posedge ref_clk);
        dma_single_busy <= 1'b0;
        wait_cpu(1'b0, 10);
        chk({5'h0, cpu_clk_en, sys_clk_en, halt_ack_cycle}, 8'h03);
        repeat (2) @(negedge ref_clk);
        chk({5'h0, cpu_clk_en, sys_clk_en, halt_ack_cycle}, 8'h02);
        chk({6'h0, bus_state.addr_pc, bus_state.data_oe}, 8'h02);
        chk({5'h0, bus_state.strobes_high, bus_state.ras_n, bus_state.cas_n}, 8'h07);
        @(posedge ref_clk);
        interrupt_disable_flag <= 1'b1;
        irq_unmasked <= 1'b1;
        far.hold(1'b1);
        repeat (10) @(negedge ref_clk);
        chk({6'h0, cpu_clk_en, bus_state.ctl_oe}, 8'h00);
        chk({7'h0, hold_acknowledge_n}, 8'h00);
        far.hold(1'b0);
        repeat (8) @(posedge ref_clk);
        interrupt_disable_flag <= 1'b0;
        wait_cpu(1'b1, 10);
        chk({7'h0, cpu_clk_en}, 8'h01);
        @(posedge ref_clk);
        irq_unmasked <= 1'b0;
        // hold raised before idle entry must stay blocked through acknowledge and early refresh
        wr(SMC_CTRL_OFS, 8'h72);
        far.hold(1'b1);
        halt();
        seen = 1'b0;
        repeat (8) @(negedge ref_clk) seen = seen | (hold_acknowledge_n !== 1'b1);
        chk({7'h0, seen}, 8'h00);
        repeat (14) @(negedge ref_clk);
        chk({4'h0, hold_acknowledge_n, sys_clk_en, cpu_clk_en, bus_state.ctl_oe}, 8'h00);
        far.hold(1'b0);
        seen = 1'b0;
        repeat (12) @(negedge ref_clk) seen = seen | (bus_state.refresh_request_out_n === 1'b0);
        chk({7'h0, seen}, 8'h01);
        @(posedge ref_clk);
        irq_unmasked <= 1'b1;
        repeat (10) @(negedge ref_clk);
        chk({7'h0, cpu_clk_en}, 8'h00);
        @(posedge ref_clk);
        irq_unmasked <= 1'b0;
        fork
            far.nmi_pulse();
        join_none
        wait_cpu(1'b1, 60);
        chk({6'h0, cpu_clk_en, sys_clk_en}, 8'h03);
        chk({7'h0, nmi_wake}, 8'h01);
        repeat (8) @(posedge ref_clk);
        halt();
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        chk({5'h0, cpu_clk_en, sys_clk_en, hold_acknowledge_n}, 8'h07);
        rd(SMC_CTRL_OFS, d);
        chk(d, 8'h00);
        close_out();
    end
endmodule // test_standby_mode_controller
